// ==== ncpd_host.sv ====
// Host model: CPU side of the command register port.
`timescale 1ns/100ps
`default_nettype none
`include "ncpd_params.svh"
module ncpd_host (
	input wire logic clock,
	output logic [`NCPD_ADDR_W-1:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata
);
	// Bus idle from time zero
	initial begin
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One-cycle write; released data inverted so stale values never match
	task automatic put(input logic [`NCPD_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	// One-cycle read; data taken once the answering edge has landed
	task automatic get(input logic [`NCPD_ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Load the command word, then launch through the completion flag
	task automatic cmd(input logic [7:0] c, input logic [23:0] a);
		put(`NCPD_REG_PARAM0, {c, a});
		put(`NCPD_REG_STATUS, 32'h0000_0001);
	endtask
endmodule
`default_nettype wire

// ==== ncpd_params.svh ====
// Constants for the nvm command permit decoder: offsets, fields, codes.
// Functional notes
// - Permission depends on mode and security
// - Secured special mode permits no command
// - 0x01 verify all blocks erased
// - 0x02 erase check one block
// - 0x03/0x10 erase check word run
// - 0x04 reads 64-byte one-time field
// - 0x07 programs one-time field once only
// - 0x06 programs one program-flash phrase
// - 0x08 erase all, unsecured special only
// - Erase all needs all protection bits set
// - 0x09 block erase needs pflash bits set
// - 0x09 on eeprom needs eeprom open bit
// - 0x0A erases one program-flash sector
// - 0x0B unsecure, unsecured special only
// - 0x0C key check, normal mode only
// - 0x0D sets user margin level
// - 0x0E field margin, unsecured special only
// - 0x11 programs one to four eeprom words
// - 0x12 erases one eeprom sector
// - 0x13 key-checked protection override
// - Writing one clears completion flag, launches
// - Invalid code raises access error, no run
`ifndef NCPD_PARAMS_SVH
`define NCPD_PARAMS_SVH
// Register indices, one word each
`define NCPD_ADDR_W 3
`define NCPD_REG_PARAM0 3'h0
`define NCPD_REG_PARAM1 3'h1
`define NCPD_REG_STATUS 3'h2
`define NCPD_REG_PROT 3'h3
`define NCPD_REG_RESULT 3'h4
`define NCPD_REG_ONCE 3'h5
// Status bits
`define NCPD_ST_CCF 0
`define NCPD_ST_ACC 1
// Protection register bits
`define NCPD_PR_PLOW 0
`define NCPD_PR_PHIGH 1
`define NCPD_PR_POPEN 2
`define NCPD_PR_EOPEN 3
// Command codes
`define NCPD_C_VALL 8'h01
`define NCPD_C_VBLK 8'h02
`define NCPD_C_VPSEC 8'h03
`define NCPD_C_RONCE 8'h04
`define NCPD_C_PPF 8'h06
`define NCPD_C_PONCE 8'h07
`define NCPD_C_EALL 8'h08
`define NCPD_C_EBLK 8'h09
`define NCPD_C_EPSEC 8'h0A
`define NCPD_C_UNSEC 8'h0B
`define NCPD_C_KEY 8'h0C
`define NCPD_C_UMARG 8'h0D
`define NCPD_C_FMARG 8'h0E
`define NCPD_C_VESEC 8'h10
`define NCPD_C_PEE 8'h11
`define NCPD_C_EESEC 8'h12
`define NCPD_C_POVR 8'h13
// Simulated operation length in cycles
`define NCPD_BUSY_CYC 4'h4
`define NCPD_EE_BIT 23
`endif

// ==== ncpd_pkg.sv ====
// Types for the nvm command permit decoder.
package ncpd_pkg;
	// Operation selected by a command code
	typedef enum logic [4:0] {
		NCPD_OP_NONE = 5'h00,
		NCPD_OP_VERIFY_ALL = 5'h01,
		NCPD_OP_VERIFY_BLOCK = 5'h02,
		NCPD_OP_VERIFY_SECTION = 5'h03,
		NCPD_OP_READ_ONCE = 5'h04,
		NCPD_OP_PROG_PHRASE = 5'h06,
		NCPD_OP_PROG_ONCE = 5'h07,
		NCPD_OP_ERASE_ALL = 5'h08,
		NCPD_OP_ERASE_BLOCK = 5'h09,
		NCPD_OP_ERASE_PSECTOR = 5'h0A,
		NCPD_OP_UNSECURE = 5'h0B,
		NCPD_OP_KEY_CHECK = 5'h0C,
		NCPD_OP_USER_MARGIN = 5'h0D,
		NCPD_OP_FIELD_MARGIN = 5'h0E,
		NCPD_OP_VERIFY_ESECTION = 5'h10,
		NCPD_OP_PROG_EEPROM = 5'h11,
		NCPD_OP_ERASE_ESECTOR = 5'h12,
		NCPD_OP_PROT_OVERRIDE = 5'h13
	} ncpd_op_t;
	// Controller states
	typedef enum logic [1:0] {
		NCPD_IDLE = 2'b01,
		NCPD_BUSY = 2'b10
	} ncpd_state_t;
	// Launch result carried to the operation engine
	typedef struct packed {
		logic valid;
		logic eeprom;
		ncpd_op_t op;
	} ncpd_launch_t;
endpackage

// ==== ncpd_top.sv ====
// Command permit decoder: register port, launch checks, busy tracking.
`timescale 1ns/100ps
`default_nettype none
`include "ncpd_params.svh"
module ncpd_top
	import ncpd_pkg::*;
#(
	parameter int BUSY_CYCLES = 4
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic normal_single_chip,
	input wire logic secured,
	input wire logic [`NCPD_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic command_complete_flag,
	output logic access_error_flag,
	output ncpd_launch_t launch,
	output logic op_busy
);
	// Permission matrix, one column per mode/security pair:
	//   sel = {secured, normal_single_chip}
	//   01 unsecured normal, 00 unsecured special,
	//   11 secured normal,   10 secured special (nothing runs).
	// Most codes run in the three open columns. Erase all, unsecure
	// and field margin need the unsecured special column only, and
	// the key check needs a normal column, secured or not.
	// Unknown codes fall to the default arm and refuse, so a new
	// code must be added here before it can ever launch.
	// Keeping the matrix in one function means the launch path and
	// the access error flag cannot drift apart on a mode decision.

	// Permission lookup: one bit per mode/security pair, shared by decode
	function automatic logic permitted(input logic [7:0] code,
		input logic ns, input logic sec);
		logic [1:0] sel;
		logic ok;
		sel = {sec, ns};
		ok = 1'b0;
		if (sel != 2'b10) begin
			unique case (code)
				`NCPD_C_VALL, `NCPD_C_VBLK, `NCPD_C_VPSEC,
				`NCPD_C_RONCE, `NCPD_C_PPF, `NCPD_C_PONCE,
				`NCPD_C_EBLK, `NCPD_C_EPSEC, `NCPD_C_UMARG,
				`NCPD_C_VESEC, `NCPD_C_PEE, `NCPD_C_EESEC,
				`NCPD_C_POVR: begin
					ok = 1'b1;
				end
				`NCPD_C_EALL, `NCPD_C_UNSEC, `NCPD_C_FMARG: begin
					ok = (sel == 2'b00);
				end
				`NCPD_C_KEY: begin
					ok = ns;
				end
				default: begin
					ok = 1'b0;
				end
			endcase
		end
		return ok;
	endfunction

	// Code to operation map
	function automatic ncpd_op_t code_op(input logic [7:0] code);
		ncpd_op_t o;
		o = NCPD_OP_NONE;
		if (code[7:5] == 3'h0) begin
			o = ncpd_op_t'(code[4:0]);
		end
		return o;
	endfunction

	logic [31:0] param0; // Code in [31:24], address in [23:0]
	logic [31:0] param1; // Data word
	logic plow, phigh, popen, eopen; // Protection bits
	logic once_done; // One-time field already written
	logic [3:0] busy_cnt; // Remaining operation cycles
	ncpd_state_t state;
	logic [7:0] code;
	logic launch_req;
	logic ok_code, ok_prot, ok_all;
	logic [31:0] next_rdata;
	logic grant_ok; // Launch in an open column with no error pending

	assign code = param0[31:24];
	// Launch is a one written to the completion bit while idle
	assign launch_req = wr && addr == `NCPD_REG_STATUS
		&& wdata[`NCPD_ST_CCF] && state == NCPD_IDLE;
	// Shorthand for the checks: a launch that only its code or protection can refuse
	assign grant_ok = launch_req && !access_error_flag
		&& !(secured && !normal_single_chip);

	// Evaluated once, on current settings, in the launch cycle
	always_comb begin
		ok_code = permitted(code, normal_single_chip, secured);
		ok_prot = 1'b1;
		if (code == `NCPD_C_EALL) begin
			ok_prot = plow & phigh & popen & eopen;
		end else if (code == `NCPD_C_EBLK) begin
			// Address bit picks eeprom or program flash block
			if (param0[`NCPD_EE_BIT]) begin
				ok_prot = eopen;
			end else begin
				ok_prot = plow & phigh & popen;
			end
		end else if (code == `NCPD_C_PONCE) begin
			ok_prot = !once_done;
		end
		ok_all = ok_code & ok_prot;
	end

	// Parameter words, locked while busy so a running command is stable
	always_ff @(posedge clock) begin
		if (!nrst) begin
			param0 <= 32'h0000_0000;
			param1 <= 32'h0000_0000;
		end else if (wr && state == NCPD_IDLE) begin
			if (addr == `NCPD_REG_PARAM0) begin
				param0 <= wdata;
			end
			if (addr == `NCPD_REG_PARAM1) begin
				param1 <= wdata;
			end
		end
	end

	// Protection register, writable only while idle
	always_ff @(posedge clock) begin
		if (!nrst) begin
			{eopen, popen, phigh, plow} <= 4'h0;
		end else if (wr && addr == `NCPD_REG_PROT && state == NCPD_IDLE) begin
			plow <= wdata[`NCPD_PR_PLOW];
			phigh <= wdata[`NCPD_PR_PHIGH];
			popen <= wdata[`NCPD_PR_POPEN];
			eopen <= wdata[`NCPD_PR_EOPEN];
		end
	end

	// Controller: launch, busy count, completion
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state <= NCPD_IDLE;
			busy_cnt <= 4'h0;
			command_complete_flag <= 1'b1;
			op_busy <= 1'b0;
		end else begin
			unique case (state)
				NCPD_IDLE: begin
					if (launch_req && ok_all && !access_error_flag) begin
						state <= NCPD_BUSY;
						busy_cnt <= 4'(BUSY_CYCLES);
						command_complete_flag <= 1'b0;
						op_busy <= 1'b1;
					end
				end
				NCPD_BUSY: begin
					if (busy_cnt == 4'h1) begin
						state <= NCPD_IDLE;
						command_complete_flag <= 1'b1;
						op_busy <= 1'b0;
					end
					busy_cnt <= busy_cnt - 4'h1;
				end
			endcase
		end
	end

	// Launch pulse to the array engine; refused codes never raise valid, but op and eeprom follow param0 every cycle
	always_ff @(posedge clock) begin
		if (!nrst) begin
			launch <= '0;
		end else begin
			launch.valid <= launch_req && ok_all && !access_error_flag;
			launch.op <= code_op(code);
			launch.eeprom <= param0[`NCPD_EE_BIT];
		end
	end

	// Access error: set by refused launch, set wins over a clear write
	always_ff @(posedge clock) begin
		if (!nrst) begin
			access_error_flag <= 1'b0;
		end else if (launch_req && !ok_all) begin
			access_error_flag <= 1'b1;
		end else if (wr && addr == `NCPD_REG_STATUS
			&& wdata[`NCPD_ST_ACC]) begin
			access_error_flag <= 1'b0;
		end
	end

	// One-time field: marked written at a granted program-once launch
	always_ff @(posedge clock) begin
		if (!nrst) begin
			once_done <= 1'b0;
		end else if (launch_req && ok_all && !access_error_flag
			&& code == `NCPD_C_PONCE) begin
			once_done <= 1'b1;
		end
	end

	// Read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (addr)
			`NCPD_REG_PARAM0: next_rdata = param0;
			`NCPD_REG_PARAM1: next_rdata = param1;
			`NCPD_REG_STATUS: begin
				next_rdata[`NCPD_ST_CCF] = command_complete_flag;
				next_rdata[`NCPD_ST_ACC] = access_error_flag;
			end
			`NCPD_REG_PROT: next_rdata[3:0] = {eopen, popen, phigh, plow};
			`NCPD_REG_RESULT: next_rdata[7:0] = {3'h0, code_op(code)};
			`NCPD_REG_ONCE: next_rdata[0] = once_done;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rd ? next_rdata : 32'h0000_0000;
		end
	end

	// Secured special never starts anything
	secured_special_a: assert property (@(posedge clock) disable iff (!nrst)
		launch_req && secured && !normal_single_chip
		|=> access_error_flag && !launch.valid)
		else $error("secured special launch accepted");
	erase_all_prot_a: assert property (@(posedge clock) disable iff (!nrst)
		launch_req && code == `NCPD_C_EALL && !(plow & phigh & popen & eopen)
		|=> !launch.valid && access_error_flag)
		else $error("erase all without protection bits");
	key_mode_a: assert property (@(posedge clock) disable iff (!nrst)
		launch_req && code == `NCPD_C_KEY && !normal_single_chip
		|=> !launch.valid)
		else $error("key check outside normal mode");
	ee_block_a: assert property (@(posedge clock) disable iff (!nrst)
		launch_req && code == `NCPD_C_EBLK && param0[`NCPD_EE_BIT] && !eopen
		|=> !launch.valid)
		else $error("eeprom block erase without open bit");
	// Flag low while running, back high after the busy count
	busy_flag_a: assert property (@(posedge clock)
		disable iff (!nrst)
		launch.valid |-> !command_complete_flag
		##BUSY_CYCLES command_complete_flag)
		else $error("completion flag timing wrong");
	invalid_code_a: assert property (@(posedge clock) disable iff (!nrst)
		launch_req && code_op(code) == NCPD_OP_NONE
		|=> access_error_flag && command_complete_flag)
		else $error("invalid code not refused");
	once_only_a: assert property (@(posedge clock) disable iff (!nrst)
		launch_req && code == `NCPD_C_PONCE && once_done
		|=> !launch.valid)
		else $error("one-time field written twice");
	special_only_a: assert property (@(posedge clock) disable iff (!nrst)
		launch_req && (code == `NCPD_C_UNSEC || code == `NCPD_C_FMARG)
		&& (secured || normal_single_chip) |=> !launch.valid)
		else $error("special-only command accepted");
	launch_c: cover property (@(posedge clock) launch.valid);
	refuse_c: cover property (@(posedge clock)
		launch_req && !ok_all);
	erase_all_c: cover property (@(posedge clock)
		launch.valid && launch.op == NCPD_OP_ERASE_ALL);
	once_c: cover property (@(posedge clock)
		launch.valid && launch.op == NCPD_OP_PROG_ONCE);

	// Granted codes: each open-column code except 0x07 and 0x09 must reach the engine,
	// with its own operation for all but the word-run checks, so a dropped matrix entry shows here.
	verify_all_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_VALL
		|=> launch.valid && launch.op == NCPD_OP_VERIFY_ALL)
		else $error("verify all refused");

	// Single block erase check in any open column
	verify_block_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_VBLK
		|=> launch.valid && launch.op == NCPD_OP_VERIFY_BLOCK)
		else $error("verify block refused");

	// Word-run checks, program flash and eeprom flavours
	verify_run_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && (code == `NCPD_C_VPSEC || code == `NCPD_C_VESEC)
		|=> launch.valid)
		else $error("section verify refused");

	// Reading the one-time field is never gated by once_done
	read_once_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_RONCE
		|=> launch.valid && launch.op == NCPD_OP_READ_ONCE)
		else $error("read once refused");

	// Phrase program in any open column
	prog_phrase_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_PPF
		|=> launch.valid && launch.op == NCPD_OP_PROG_PHRASE)
		else $error("phrase program refused");

	// Erase all only in the unsecured special column
	erase_all_mode_a: assert property (@(posedge clock)
		disable iff (!nrst)
		launch_req && code == `NCPD_C_EALL
		&& (secured || normal_single_chip)
		|=> !launch.valid)
		else $error("erase all outside unsecured special");

	// Full program-flash block erase needs all three pflash bits
	block_prot_a: assert property (@(posedge clock)
		disable iff (!nrst)
		launch_req && code == `NCPD_C_EBLK && !param0[`NCPD_EE_BIT]
		&& !(plow & phigh & popen)
		|=> !launch.valid)
		else $error("pflash block erase without protection bits");

	// Program-flash sector erase in any open column
	psector_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_EPSEC
		|=> launch.valid && launch.op == NCPD_OP_ERASE_PSECTOR)
		else $error("pflash sector erase refused");

	// Key check runs in either normal column
	key_allow_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_KEY && normal_single_chip
		|=> launch.valid && launch.op == NCPD_OP_KEY_CHECK)
		else $error("key check refused in normal mode");

	// User margin in any open column
	user_margin_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_UMARG
		|=> launch.valid && launch.op == NCPD_OP_USER_MARGIN)
		else $error("user margin refused");

	// Field margin only in the unsecured special column
	field_margin_a: assert property (@(posedge clock)
		disable iff (!nrst)
		launch_req && code == `NCPD_C_FMARG
		&& (secured || normal_single_chip)
		|=> !launch.valid)
		else $error("field margin outside unsecured special");

	// Eeprom word program in any open column
	ee_prog_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_PEE
		|=> launch.valid && launch.op == NCPD_OP_PROG_EEPROM)
		else $error("eeprom program refused");

	// Eeprom sector erase in any open column
	ee_sector_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_EESEC
		|=> launch.valid && launch.op == NCPD_OP_ERASE_ESECTOR)
		else $error("eeprom sector erase refused");

	// Protection override in any open column
	override_a: assert property (@(posedge clock)
		disable iff (!nrst)
		grant_ok && code == `NCPD_C_POVR
		|=> launch.valid && launch.op == NCPD_OP_PROT_OVERRIDE)
		else $error("protection override refused");

	// Known but unpermitted codes refuse exactly like unknown ones
	refuse_known_a: assert property (@(posedge clock)
		disable iff (!nrst)
		launch_req && !ok_code
		|=> !launch.valid && access_error_flag && command_complete_flag)
		else $error("unpermitted code started");

	// Settings sampled at launch must not move under a running command
	prot_lock_a: assert property (@(posedge clock)
		disable iff (!nrst)
		state == NCPD_BUSY && wr && addr == `NCPD_REG_PROT
		|=> {eopen, popen, phigh, plow}
		== $past({eopen, popen, phigh, plow}))
		else $error("protection changed while busy");
endmodule
`default_nettype wire

// ==== ncpd_top_tb.sv ====
// Self-checking bench for the command permit decoder.
`timescale 1ns/100ps
`default_nettype none
`include "ncpd_params.svh"
module ncpd_top_tb;
	import ncpd_pkg::*;
	localparam int BUSY = 3; // Shortened array operation
	logic clock, nrst, normal_single_chip, secured;
	wire logic [`NCPD_ADDR_W-1:0] addr;
	wire logic [31:0] wdata;
	wire logic wr, rd;
	logic [31:0] rdata, rv;
	logic command_complete_flag, access_error_flag, op_busy;
	ncpd_launch_t launch;
	int mismatches, n_tests;
	logic [31:0] seed = 32'h12ab_e284; // Fixed start for repeatability
	bit once_done; // Model: one-time field already written
	logic [3:0] prot; // Model copy of the protection bits
	ncpd_top #(.BUSY_CYCLES(BUSY)) ncpd_top_i (.clock(clock), .nrst(nrst),
		.normal_single_chip(normal_single_chip), .secured(secured),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.command_complete_flag(command_complete_flag),
		.access_error_flag(access_error_flag), .launch(launch),
		.op_busy(op_busy));
	ncpd_host ncpd_host_i (.clock(clock), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Model: may this code run now, protection included
	function automatic bit allowed(input logic [7:0] c, input logic ns,
		input logic sec, input logic ee);
		if (sec && !ns) return 0;
		case (c)
			8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h0A, 8'h0D: return 1;
			8'h10, 8'h11, 8'h12, 8'h13: return 1;
			8'h07: return !once_done;
			8'h08: return !ns && !sec && prot == 4'hF;
			8'h09: return ee ? prot[3] : prot[2:0] == 3'h7;
			8'h0B, 8'h0E: return !ns && !sec;
			8'h0C: return ns;
			default: return 0;
		endcase
	endfunction
	task automatic chk1(input logic got, input logic exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s %h/%h", $time, what, got, exp);
		end
	endtask
	// Launch one command and compare with the model
	task automatic run(input logic [7:0] c, input logic [23:0] a,
		input logic ns, input logic sec);
		bit ok;
		int n;
		@(posedge clock);
		normal_single_chip <= ns;
		secured <= sec;
		ok = allowed(c, ns, sec, a[`NCPD_EE_BIT]);
		ncpd_host_i.cmd(c, a);
		#1;
		chk1(launch.valid, ok, "launch");
		chk1(access_error_flag, !ok, "error");
		chk1(command_complete_flag, !ok, "complete");
		if (ok) begin
			chk32({27'h0, launch.op}, {27'h0, c[4:0]}, "op");
			chk1(launch.eeprom, a[`NCPD_EE_BIT], "ee");
			chk1(op_busy, 1'b1, "busy");
			if (c == 8'h07) once_done = 1;
			n = 0;
			while (command_complete_flag !== 1'b1 && n < 40) begin
				@(posedge clock);
				#1;
				n++;
			end
			chk32(32'(n), 32'(BUSY), "busy length");
			chk1(op_busy, 1'b0, "idle after run");
			ncpd_host_i.get(`NCPD_REG_RESULT, rv);
			chk32(rv, {27'h0, c[4:0]}, "result");
			ncpd_host_i.get(`NCPD_REG_ONCE, rv);
			chk32(rv, {31'h0, once_done}, "once flag");
		end else if (access_error_flag === 1'b1) begin
			// Error must be cleared before the next launch
			ncpd_host_i.put(`NCPD_REG_STATUS, 32'h0000_0002);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d, comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge clock);
		mismatches++;
		finish_test;
	end
	initial begin
		nrst = 1'b0;
		normal_single_chip = 1'b1;
		secured = 1'b0;
		mismatches = 0;
		n_tests = 0;
		once_done = 0;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		ncpd_host_i.get(`NCPD_REG_STATUS, rv);
		chk32(rv, 32'h0000_0001, "status at reset");
		ncpd_host_i.get(3'h7, rv);
		chk32(rv, 32'h0000_0000, "unmapped");
		ncpd_host_i.put(`NCPD_REG_PARAM1, 32'h5a5a_0f0f);
		ncpd_host_i.get(`NCPD_REG_PARAM1, rv);
		chk32(rv, 32'h5a5a_0f0f, "param1");
		prot = 4'hF;
		ncpd_host_i.put(`NCPD_REG_PROT, {28'h0, prot});
		ncpd_host_i.get(`NCPD_REG_PROT, rv);
		chk32(rv, {28'h0, prot}, "protection");
		// Codes 0x00 to 0x1F in every mode and security pairing
		for (int m = 0; m < 4; m++)
			for (int c = 0; c < 32; c++)
				run(8'(c), 24'h00_0000, m[0], m[1]);
		// One protection bit missing at a time
		for (int i = 0; i < 4; i++) begin
			prot = 4'hF ^ (4'h1 << i);
			ncpd_host_i.put(`NCPD_REG_PROT, {28'h0, prot});
			run(8'h08, 24'h00_0000, 1'b0, 1'b0);
			run(8'h09, 24'h00_0000, 1'b1, 1'b0);
			run(8'h09, 24'h80_0000, 1'b1, 1'b0);
		end
		// Random codes, addresses, modes and protection
		for (int i = 0; i < 60; i++) begin
			seed = lfsr(seed);
			prot = seed[3:0];
			ncpd_host_i.put(`NCPD_REG_PROT, {28'h0, prot});
			run({3'h0, seed[28:24]}, seed[23:0], seed[5], seed[6]);
		end
		finish_test;
	end
endmodule
`default_nettype wire
